// *** hw/relay_bank_pkg.sv ***
// Purpose: Shared constants and types of the relay status and event bank
// Assumes: 32-bit APB, one aligned word per register
// Notes: Offsets are byte addresses within a 4 KiB window
package relay_bank_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_LIVE = 12'h000;
	localparam logic [11:0] OFF_EVENT = 12'h004;
	localparam logic [11:0] OFF_MASK = 12'h008;
	localparam logic [11:0] OFF_OUTWR = 12'h00c;
	localparam logic [11:0] OFF_REMOTE = 12'h010;
	localparam logic [11:0] OFF_CTRLBYTE = 12'h014;
	localparam logic [11:0] OFF_PWDOPEN = 12'h018;
	localparam logic [11:0] OFF_PWDCLOSE = 12'h01c;
	localparam logic [11:0] OFF_PWDSTAT = 12'h020;
	localparam logic [11:0] OFF_TRIP = 12'h024;
	localparam logic [6:0] CUR_PAGE = 7'h02;
	localparam logic [6:0] ANG_PAGE = 7'h03;
	localparam logic [2:0] HIST_PAGE = 3'h1;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int N_STAGE = 12;
	localparam int N_OUT = 8;
	localparam int N_EVT = 20;
	localparam int N_CUR = 6;
	localparam int N_ANG = 2;
	localparam int N_QTY = 9;
	localparam int DEPTH = 5;
	localparam int VAL_W = 16;
	localparam int ANG_W = 9;

	// ****************************************
	// Bit positions and ranges
	// ****************************************
	localparam int ST_OP1 = 1;
	localparam int ST_OP2 = 4;
	localparam logic [15:0] CUR_MAX = 16'h1996;
	localparam logic [15:0] ANG_MAX = 16'h0167;
	localparam logic [8:0][15:0] HIST_MAX = {16'h007f, 16'h0064,
		16'h0bb8, 16'h0064, 16'h0bb8, 16'h199a, 16'h199a,
		16'h199a, 16'h199a};

	// ****************************************
	// Reset values and password limits
	// ****************************************
	localparam logic [19:0] EVENT_RST = 20'h00000;
	localparam logic [19:0] MASK_RST = 20'h00000;
	localparam logic [9:0] PWD_DEFAULT = 10'h001;
	localparam logic [9:0] PWD_MAX = 10'h3e7;
	localparam logic [2:0] PWD_TRIES = 3'h7;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		TRIP_NONE = 2'b00,
		TRIP_ONE = 2'b01,
		TRIP_TWO = 2'b10,
		TRIP_BOTH = 2'b11
	} trip_code_t;

	typedef enum logic [1:0] {
		PW_CLOSED = 2'b00,
		PW_OPEN = 2'b01,
		PW_LOCKED = 2'b10
	} pw_state_t;

	// Saturate a value to the top of its range
	function automatic logic [15:0] clampVal(input logic [15:0] v,
		input logic [15:0] m);
		return (v > m) ? m : v;
	endfunction

endpackage

// *** hw/hist_if.sv ***
// Purpose: Link between the register bank and its history store
// Assumes: Single clock, store answers reads combinationally
// Notes: record is a one-cycle pulse
`timescale 1ns/1ps
interface hist_if;
	logic record;
	logic [8:0][15:0] sample;
	logic [3:0] rdQty;
	logic [2:0] rdSlot;
	logic [15:0] rdData;
	modport bank(output record, output sample, output rdQty,
		output rdSlot, input rdData);
	modport store(input record, input sample, input rdQty,
		input rdSlot, output rdData);
endinterface

// *** hw/history_store.sv ***
// Purpose: Five-deep shift history of each recorded fault quantity
// Assumes: Reads are address-only, no side effects
// Notes: Slot 0 is the newest value, slot 4 the oldest
`timescale 1ns/1ps
module history_store (
	// Clock and reset
	input logic sys_clk,
	input logic rst,
	// Bank side
	hist_if.store h
);

	// ****************************************
	// Slot storage
	// ****************************************
	logic [15:0] slot_reg [relay_bank_pkg::N_QTY][relay_bank_pkg::DEPTH];
	logic [15:0] slot_next [relay_bank_pkg::N_QTY][relay_bank_pkg::DEPTH];

	// Shift one place older on record, oldest value falls off
	genvar q;
	generate
		for (q = 0; q < relay_bank_pkg::N_QTY; q++) begin : gQty
			always_comb begin
				for (int s = 0; s < relay_bank_pkg::DEPTH; s++) begin
					slot_next[q][s] = slot_reg[q][s];
				end
				if (h.record) begin
					// Ranges cap percentages and ratios
					slot_next[q][0] = relay_bank_pkg::clampVal(
						h.sample[q], relay_bank_pkg::HIST_MAX[q]);
					for (int s = 1; s < relay_bank_pkg::DEPTH; s++) begin
						slot_next[q][s] = slot_reg[q][s-1];
					end
				end
			end
			always_ff @(posedge sys_clk) begin
				for (int s = 0; s < relay_bank_pkg::DEPTH; s++) begin
					if (rst) begin
						slot_reg[q][s] <= 16'h0000;
					end else begin
						slot_reg[q][s] <= slot_next[q][s];
					end
				end
			end
		end
	endgenerate

	// Read port; out-of-range indices return zero
	always_comb begin
		h.rdData = 16'h0000;
		if (h.rdQty < 4'(relay_bank_pkg::N_QTY) &&
			h.rdSlot < 3'(relay_bank_pkg::DEPTH)) begin
			h.rdData = slot_reg[h.rdQty][h.rdSlot];
		end
	end

endmodule

// *** hw/relay_status_event_record_bank.sv ***
// Purpose: Remotely readable status, event and fault record bank
// Assumes: APB slave, zero wait states, inputs synchronous to sys_clk
// Notes: Reading the event register clears its latched bits
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module relay_status_event_record_bank #(
	parameter logic [9:0] PWD_INIT = relay_bank_pkg::PWD_DEFAULT
) (
	// Clock and reset
	input logic sys_clk,
	input logic rst,
	// APB slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Protection stages and control signals
	input logic [11:0] stageLive,
	input logic [7:0] outSigIn,
	input logic [7:0] controlStatusByte,
	// Measurements
	input logic [5:0][15:0] phaseCur,
	input logic [1:0][8:0] phaseAngle,
	// Fault recording
	input logic recordStrobe,
	input logic [8:0][15:0] recordSample,
	// Outputs to the module
	output logic [7:0] outSigDrive,
	output logic remoteOutCtrlFlag,
	output logic [1:0] tripOriginCode,
	output logic irq
);

	// ****************************************
	// Declarations
	// ****************************************
	hist_if hist ();

	logic [31:0] prdata_reg, prdata_next;
	logic slverr_reg, slverr_next;
	logic [19:0] eventLatch_reg, eventLatch_next;
	logic [19:0] mask_reg, mask_next;
	logic [7:0] outWr_reg, outWr_next;
	logic [7:0] outDrive_reg, outDrive_next;
	logic remote_reg, remote_next;
	relay_bank_pkg::trip_code_t trip_reg, trip_next;
	relay_bank_pkg::pw_state_t pwState_reg, pwState_next;
	logic [9:0] pwd_reg, pwd_next;
	logic [2:0] fails_reg, fails_next;
	logic [31:0] rdVal;
	logic rdOk;
	logic isProt;
	logic setup;
	logic access;
	logic wrDone;
	logic rdEvent;
	logic [7:0] outStatus;
	logic [19:0] evtLive;
	logic [1:0] tripNow;
	logic [2:0] idx;

	// ****************************************
	// History store
	// ****************************************
	history_store uHist (
		.sys_clk(sys_clk),
		.rst(rst),
		.h(hist.store)
	);

	// Record strobe and address into the store
	assign hist.record = recordStrobe;
	assign hist.sample = recordSample;
	assign hist.rdQty = paddr[8:5];
	assign hist.rdSlot = paddr[4:2];

	// ****************************************
	// APB phase decode
	// ****************************************
	// Zero wait states: every access completes in its first access cycle
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wrDone = access & pwrite & ~slverr_reg;
	assign rdEvent = access & ~pwrite & ~slverr_reg &
		(paddr == relay_bank_pkg::OFF_EVENT);
	assign idx = paddr[4:2];
	assign pready = 1'b1;
	assign pslverr = slverr_reg & access;
	assign prdata = prdata_reg;

	// ****************************************
	// Live status
	// ****************************************
	// Remote flag hands the output signals over to the written word
	assign outStatus = remote_reg ? outWr_reg : outSigIn;
	assign evtLive = {outStatus, stageLive};
	assign tripNow = {stageLive[relay_bank_pkg::ST_OP2],
		stageLive[relay_bank_pkg::ST_OP1]};
	assign outSigDrive = outDrive_reg;
	assign remoteOutCtrlFlag = remote_reg;
	assign tripOriginCode = trip_reg;
	assign irq = |(eventLatch_reg & mask_reg);

	// ****************************************
	// Read decode
	// ****************************************
	// Also flags unmapped addresses and password protected targets
	always_comb begin
		rdVal = 32'h00000000;
		rdOk = 1'b1;
		isProt = 1'b0;
		if (paddr[11:9] == relay_bank_pkg::HIST_PAGE) begin
			rdOk = (paddr[8:5] < 4'(relay_bank_pkg::N_QTY)) &&
				(idx < 3'(relay_bank_pkg::DEPTH));
			rdVal = {16'h0000, hist.rdData};
		end else if (paddr[11:5] == relay_bank_pkg::CUR_PAGE) begin
			rdOk = idx < 3'(relay_bank_pkg::N_CUR);
			if (rdOk) begin
				rdVal = {16'h0000, relay_bank_pkg::clampVal(phaseCur[idx],
					relay_bank_pkg::CUR_MAX)};
			end
		end else if (paddr[11:5] == relay_bank_pkg::ANG_PAGE) begin
			rdOk = idx < 3'(relay_bank_pkg::N_ANG);
			if (rdOk) begin
				rdVal = {16'h0000, relay_bank_pkg::clampVal(
					{7'h00, phaseAngle[idx[0]]},
					relay_bank_pkg::ANG_MAX)};
			end
		end else begin
			case (paddr)
				relay_bank_pkg::OFF_LIVE: begin
					rdVal = {12'h000, evtLive};
				end
				relay_bank_pkg::OFF_EVENT: begin
					rdVal = {12'h000, eventLatch_reg};
				end
				relay_bank_pkg::OFF_MASK: begin
					rdVal = {12'h000, mask_reg};
				end
				relay_bank_pkg::OFF_OUTWR: begin
					rdVal = {24'h000000, outWr_reg};
					isProt = 1'b1;
				end
				relay_bank_pkg::OFF_REMOTE: begin
					rdVal = {31'h00000000, remote_reg};
					isProt = 1'b1;
				end
				relay_bank_pkg::OFF_CTRLBYTE: begin
					rdVal = {24'h000000, controlStatusByte};
				end
				relay_bank_pkg::OFF_PWDOPEN: begin
					rdVal = 32'h00000000;
				end
				relay_bank_pkg::OFF_PWDCLOSE: begin
					rdVal = 32'h00000000;
				end
				relay_bank_pkg::OFF_PWDSTAT: begin
					rdVal = {30'h00000000, pwState_reg};
				end
				relay_bank_pkg::OFF_TRIP: begin
					rdVal = {30'h00000000, trip_reg};
				end
				default: begin
					rdOk = 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Bus answer
	// ****************************************
	// Answer is built in the setup cycle so it is ready at access
	always_comb begin
		prdata_next = prdata_reg;
		slverr_next = slverr_reg;
		if (setup) begin
			prdata_next = (pwrite || !rdOk) ? 32'h00000000 : rdVal;
			slverr_next = !rdOk || (pwrite && isProt &&
				pwState_reg != relay_bank_pkg::PW_OPEN);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata_reg <= 32'h00000000;
			slverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			slverr_reg <= slverr_next;
		end
	end

	// ****************************************
	// Events, mask, outputs and trip code
	// ****************************************
	// A signal active in the clearing cycle stays latched
	always_comb begin
		eventLatch_next = (rdEvent ? relay_bank_pkg::EVENT_RST :
			eventLatch_reg) | evtLive;
		mask_next = mask_reg;
		outWr_next = outWr_reg;
		remote_next = remote_reg;
		trip_next = trip_reg;
		outDrive_next = outStatus;
		if (wrDone && paddr == relay_bank_pkg::OFF_MASK) begin
			mask_next = pwdata[19:0];
		end
		if (wrDone && paddr == relay_bank_pkg::OFF_OUTWR) begin
			outWr_next = pwdata[7:0];
		end
		if (wrDone && paddr == relay_bank_pkg::OFF_REMOTE) begin
			remote_next = pwdata[0];
		end
		// Code only changes when at least one stage has tripped
		if (recordStrobe && tripNow != 2'b00) begin
			trip_next = relay_bank_pkg::trip_code_t'(tripNow);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			eventLatch_reg <= relay_bank_pkg::EVENT_RST;
			mask_reg <= relay_bank_pkg::MASK_RST;
			outWr_reg <= 8'h00;
			outDrive_reg <= 8'h00;
			remote_reg <= 1'b0;
			trip_reg <= relay_bank_pkg::TRIP_NONE;
		end else begin
			eventLatch_reg <= eventLatch_next;
			mask_reg <= mask_next;
			outWr_reg <= outWr_next;
			outDrive_reg <= outDrive_next;
			remote_reg <= remote_next;
			trip_reg <= trip_next;
		end
	end

	// ****************************************
	// Password
	// ****************************************
	// Seven wrong tries lock out protected writes; only a reset reopens the path
	always_comb begin
		pwState_next = pwState_reg;
		pwd_next = pwd_reg;
		fails_next = fails_reg;
		unique case (pwState_reg)
			relay_bank_pkg::PW_CLOSED: begin
				if (wrDone && paddr == relay_bank_pkg::OFF_PWDOPEN) begin
					if (pwdata[9:0] == pwd_reg && pwdata[31:10] == 22'h0) begin
						pwState_next = relay_bank_pkg::PW_OPEN;
						fails_next = 3'h0;
					end else if (fails_reg ==
						relay_bank_pkg::PWD_TRIES - 3'h1) begin
						pwState_next = relay_bank_pkg::PW_LOCKED;
						pwd_next = 10'h000;
					end else begin
						fails_next = fails_reg + 3'h1;
					end
				end
			end
			relay_bank_pkg::PW_OPEN: begin
				if (wrDone && paddr == relay_bank_pkg::OFF_PWDCLOSE) begin
					pwState_next = relay_bank_pkg::PW_CLOSED;
					// A legal value also becomes the new password
					if (pwdata[31:10] == 22'h0 && pwdata[9:0] != 10'h000 &&
						pwdata[9:0] <= relay_bank_pkg::PWD_MAX) begin
						pwd_next = pwdata[9:0];
					end
				end
			end
			relay_bank_pkg::PW_LOCKED: begin
				pwState_next = relay_bank_pkg::PW_LOCKED;
			end
			default: begin
				pwState_next = relay_bank_pkg::PW_CLOSED;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pwState_reg <= relay_bank_pkg::PW_CLOSED;
			pwd_reg <= PWD_INIT;
			fails_reg <= 3'h0;
		end else begin
			pwState_reg <= pwState_next;
			pwd_reg <= pwd_next;
			fails_reg <= fails_next;
		end
	end

endmodule

// *** test/apb_master_model.sv ***
// Purpose: APB master standing in for the remote communicator
// Assumes: One clock; the slave may add wait states
// Notes: The answer is taken at the rising edge that sees pready high
`timescale 1ns/1ps
module apb_master_model (
	// Clock
	input logic sys_clk,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	// Answer
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// One transfer, held until pready is seen high at an edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Request stands until an edge sees pready; answer taken there
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // Released lines stop echoing the request
		pwdata <= ~d;
	endtask
	// Protected writes need the password opened first
	task automatic openPw(input logic [9:0] pw);
		logic [31:0] q;
		logic e;
		xfer(1'b1, relay_bank_pkg::OFF_PWDOPEN, {22'h0, pw}, q, e);
	endtask
endmodule

// *** test/relay_bank_chk.sv ***
// Purpose: Port-level checks of the relay record bank
// Assumes: Zero-wait APB, synchronous active-high reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module relay_bank_chk (
	// Clock and reset
	input logic sys_clk,
	input logic rst,
	// Bus
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// Module side
	input logic [11:0] stageLive,
	input logic [7:0] outSigIn,
	input logic [7:0] controlStatusByte,
	input logic recordStrobe,
	input logic [7:0] outSigDrive,
	input logic remoteOutCtrlFlag,
	input logic [1:0] tripOriginCode,
	input logic irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Read and remote-write access cycles
	logic rdAcc;
	logic remWr;
	assign rdAcc = psel && penable && !pwrite;
	assign remWr = psel && penable && pwrite
		&& paddr == relay_bank_pkg::OFF_REMOTE;
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	a_live_read: assert property (rdAcc && paddr == 12'h000
		|-> prdata[11:0] == $past(stageLive)) else $error("live read");
	a_ctrl_read: assert property (rdAcc && paddr == 12'h014
		|-> prdata == {24'h0, $past(controlStatusByte)})
		else $error("control byte read");
	a_angle_range: assert property (rdAcc && paddr[11:3] == 9'h00c
		|-> prdata <= 32'h167) else $error("angle out of range");
	a_trip_hold: assert property (!recordStrobe
		|=> $stable(tripOriginCode)) else $error("trip code moved");
	a_trip_load: assert property (recordStrobe && stageLive[1]
		|=> tripOriginCode[0] && tripOriginCode[1] == $past(stageLive[4]))
		else $error("trip code load");
	a_flag_hold: assert property (!remWr
		|=> $stable(remoteOutCtrlFlag)) else $error("flag moved");
	a_refused_write: assert property (remWr && pslverr
		|=> remoteOutCtrlFlag == $past(remoteOutCtrlFlag)[*2])
		else $error("refused write took effect");
	a_drive_follow: assert property (!remoteOutCtrlFlag
		|=> outSigDrive == $past(outSigIn)) else $error("drive lag");
	// Main scenarios reached
	c_record: cover property (recordStrobe);
	c_refused: cover property (pslverr);
	c_irq: cover property (irq);
endmodule

// *** test/test_relay_status_event_record_bank.sv ***
// Purpose: Self-checking bench of the relay record bank
// Assumes: Bus traffic goes through the master model
// Notes: Checker is bound at the foot of this file
`timescale 1ns/1ps
module test_relay_status_event_record_bank;
	// ************
	// Wiring
	// ************
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, remoteOutCtrlFlag, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [11:0] stageLive = 12'h000;
	logic [7:0] outSigIn = 8'h00;
	logic [7:0] controlStatusByte = 8'h00;
	logic [5:0][15:0] phaseCur = 96'h0;
	logic [1:0][8:0] phaseAngle = 18'h0;
	logic recordStrobe = 1'b0;
	logic [8:0][15:0] recordSample = 144'h0;
	logic [7:0] outSigDrive;
	logic [1:0] tripOriginCode;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	relay_status_event_record_bank u_dut (.sys_clk, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stageLive,
		.outSigIn, .controlStatusByte, .phaseCur, .phaseAngle,
		.recordStrobe, .recordSample, .outSigDrive, .remoteOutCtrlFlag,
		.tripOriginCode, .irq);
	apb_master_model u_bus (.sys_clk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);
	// ************
	// Helpers
	// ************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] exp, input logic err);
		logic [31:0] q;
		logic e;
		u_bus.xfer(w, a, d, q, e);
		if (!w) chk(q, exp);
		chk({31'h0, e}, {31'h0, err});
	endtask
	// Two edges let a latched input reach the outputs
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	// Recorded value of record k, quantity q, after range limiting
	function automatic logic [31:0] histExp(int k, int q);
		logic [15:0] v;
		v = (k == 6) ? 16'h00c0 : 16'(k * 16);
		v = v + 16'(q);
		if ((q == 5 || q == 7) && v > 16'h0064) v = 16'h0064;
		if (q == 8 && v > 16'h007f) v = 16'h007f;
		return {16'h0, v};
	endfunction
	task automatic rec(input logic [15:0] base, input logic [11:0] live);
		@(posedge sys_clk);
		recordStrobe <= 1'b1;
		stageLive <= live;
		for (int q = 0; q < 9; q++) recordSample[q] <= base + 16'(q);
		@(posedge sys_clk);
		recordStrobe <= 1'b0;
		stageLive <= 12'h000;
		@(negedge sys_clk);
	endtask
	// ************
	// Scenarios
	// ************
	task automatic testReset;
		acc(1'b0, relay_bank_pkg::OFF_MASK, 32'h0, 32'h0, 1'b0);
		acc(1'b0, relay_bank_pkg::OFF_PWDSTAT, 32'h0, 32'h0, 1'b0);
		acc(1'b0, relay_bank_pkg::OFF_TRIP, 32'h0, 32'h0, 1'b0);
		acc(1'b0, 12'h0fc, 32'h0, 32'h0, 1'b1);
		acc(1'b0, 12'h214, 32'h0, 32'h0, 1'b1);
		$display("reset test done");
	endtask
	task automatic testLiveEvent;
		@(posedge sys_clk);
		stageLive <= 12'h805;
		outSigIn <= 8'h81;
		acc(1'b0, 12'h000, 32'h0, 32'h81805, 1'b0);
		stageLive <= 12'h000;
		outSigIn <= 8'h00;
		acc(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
		acc(1'b0, 12'h004, 32'h0, 32'h81805, 1'b0);
		acc(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
		$display("live and event test done");
	endtask
	task automatic testMeasure;
		@(posedge sys_clk);
		controlStatusByte <= 8'ha5;
		phaseCur[0] <= 16'hffff;
		phaseCur[5] <= 16'h0123;
		phaseAngle[0] <= 9'h1ff;
		phaseAngle[1] <= 9'h05a;
		acc(1'b0, 12'h014, 32'h0, 32'h0a5, 1'b0);
		acc(1'b0, 12'h040, 32'h0, 32'h1996, 1'b0);
		acc(1'b0, 12'h054, 32'h0, 32'h0123, 1'b0);
		acc(1'b0, 12'h060, 32'h0, 32'h0167, 1'b0);
		acc(1'b0, 12'h064, 32'h0, 32'h005a, 1'b0);
		$display("measurement test done");
	endtask
	task automatic testPassword;
		acc(1'b1, 12'h010, 32'h1, 32'h0, 1'b1);
		acc(1'b0, 12'h010, 32'h0, 32'h0, 1'b0);
		u_bus.openPw(10'h001);
		acc(1'b0, 12'h020, 32'h0, 32'h1, 1'b0);
		acc(1'b1, 12'h010, 32'h1, 32'h0, 1'b0);
		acc(1'b1, 12'h00c, 32'h3c, 32'h0, 1'b0);
		settle();
		chk({24'h0, outSigDrive}, 32'h3c);
		chk({31'h0, remoteOutCtrlFlag}, 32'h1);
		acc(1'b1, 12'h010, 32'h0, 32'h0, 1'b0);
		acc(1'b1, 12'h01c, 32'h1, 32'h0, 1'b0);
		acc(1'b0, 12'h020, 32'h0, 32'h0, 1'b0);
		acc(1'b1, 12'h00c, 32'h55, 32'h0, 1'b1);
		$display("password test done");
	endtask
	task automatic testHistory;
		for (int k = 1; k <= 6; k++) begin
			rec(16'(histExp(k, 0)), (k == 1) ? 12'h002 : (k == 2) ? 12'h010
				: (k == 3) ? 12'h012 : 12'h000);
			chk({30'h0, tripOriginCode}, (k < 3) ? k : 3);
		end
		for (int q = 0; q < 9; q++)
			for (int s = 0; s < 5; s++)
				acc(1'b0, 12'h200 + 12'(q * 32 + s * 4), 32'h0,
					histExp(6 - s, q), 1'b0);
		acc(1'b0, relay_bank_pkg::OFF_TRIP, 32'h0, 32'h3, 1'b0);
		$display("history test done");
	endtask
	task automatic testIrq;
		// Remote word 0x3c showed as live output status, so it latched
		acc(1'b0, 12'h004, 32'h0, 32'h3c012, 1'b0);
		acc(1'b1, 12'h008, 32'h1, 32'h0, 1'b0);
		stageLive <= 12'h004;
		settle();
		chk({31'h0, irq}, 32'h0);
		@(posedge sys_clk);
		stageLive <= 12'h001;
		settle();
		@(posedge sys_clk);
		stageLive <= 12'h000;
		settle();
		chk({31'h0, irq}, 32'h1);
		acc(1'b0, 12'h004, 32'h0, 32'h00005, 1'b0);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		$display("interrupt test done");
	endtask
	task automatic results;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			results();
		end
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		testReset();
		testLiveEvent();
		testMeasure();
		testPassword();
		testHistory();
		testIrq();
		results();
	end
endmodule
bind relay_status_event_record_bank relay_bank_chk u_chk (.sys_clk, .rst,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.stageLive, .outSigIn, .controlStatusByte, .recordStrobe, .outSigDrive,
	.remoteOutCtrlFlag, .tripOriginCode, .irq);
